// File: logic/ssu_serial_unit.sv
// Purpose: serial_unit flags, interrupt requests, tx engine, pins
// Assumes: AXI4-Lite slave, 40 MHz CLK, one write and one read at a time
// Notes: synchronous mode uses the internal clock only

`timescale 1ns/100ps

module ssu_serial_unit #(
	parameter int DIV_W = 16
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RST,
	// write address and data
	input wire logic [ssu_pkg::ADDR_W-1:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	// write response
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	// read address and data
	input wire logic [ssu_pkg::ADDR_W-1:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	// serial pins
	input wire logic RXD,
	output logic TXD_O,
	output logic TXD_OE,
	output logic SCK_O,
	output logic SCK_OE,
	// interrupt requests
	output logic TX_EMPTY_IRQ,
	output logic TX_END_IRQ,
	output logic RX_FULL_IRQ,
	output logic RX_ERROR_IRQ,
	output logic IRQ
);
	import ssu_pkg::*;

	// =========
	// parameter check
	if (DIV_W < 1 || DIV_W > 16)
		$error("DIV_W must lie in 1..16");

	// =========
	// bytewise merge of a write into a register word
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] strb);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		return (old & ~m) | (wd & m);
	endfunction

	// =========
	// declarations
	logic [CTRL_W-1:0] ctrl_reg; // serial_control_reg
	logic [DIV_W-1:0] baud_reg; // CLK cycles per tick minus one
	logic [DIV_W-1:0] div_cnt_reg; // divider count
	logic tick_reg; // 16x base clock enable
	logic rxd_meta_reg, rxd_sync_reg; // line synchroniser
	ssu_tx_e tx_state_reg; // transmitter state
	logic [3:0] tx_cnt_reg; // ticks within a bit
	logic [2:0] tx_bit_reg; // data bit index
	logic [7:0] tx_sr_reg; // tx_shift_reg
	logic [7:0] tx_hold_reg; // tx_holding_reg
	logic [7:0] rx_hold_reg; // rx_holding_reg
	logic tx_line_reg, tx_par_reg; // line level, parity
	logic tx_empty_reg, tx_end_reg, rx_full_reg; // status flags
	logic ovr_reg, fer_reg, per_reg; // receive error flags
	logic sck_use_reg; // clock-output use last cycle
	logic wr_rdy_reg, rd_rdy_reg; // bus ready pulses
	logic wr_hs, rd_hs; // bus handshakes
	logic wr_ctrl, wr_stat, wr_txh, wr_baud, rd_rxh; // decoded access
	logic tx_irq_enable, rx_irq_enable, tx_end_irq_enable, tx_en, rx_en, sync; // control fields
	logic err_any; // any receive error flag
	logic tx_load, bit_end, tx_last; // tx events
	logic sck_use, sck_level; // clock pin control
	logic rx_done, rx_fer, rx_per; // receiver result
	logic [7:0] rx_data;
	logic sync_samp; // synchronous sample strobe
	logic [31:0] stat_word; // status read image
	logic [31:0] ctrl_merged, baud_merged; // register words after a write

	// =========
	// decode
	assign wr_hs = wr_rdy_reg && AWVALID && WVALID;
	assign rd_hs = rd_rdy_reg && ARVALID;
	assign wr_ctrl = wr_hs && AWADDR == OFF_CTRL;
	assign wr_stat = wr_hs && AWADDR == OFF_STAT && WSTRB[0];
	assign wr_txh = wr_hs && AWADDR == OFF_TXH && WSTRB[0];
	assign wr_baud = wr_hs && AWADDR == OFF_BAUD;
	assign rd_rxh = rd_hs && ARADDR == OFF_RXH;
	assign tx_irq_enable = ctrl_reg[CB_TIE];
	assign rx_irq_enable = ctrl_reg[CB_RIE];
	assign tx_end_irq_enable = ctrl_reg[CB_TX_END_IRQ_ENABLE];
	assign tx_en = ctrl_reg[CB_TE];
	assign rx_en = ctrl_reg[CB_RE];
	assign sync = ctrl_reg[CB_SYNC];
	assign err_any = ovr_reg | fer_reg | per_reg;

	// =========
	// write channel: take address and data together
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			wr_rdy_reg <= 1'b0;
			BVALID <= 1'b0;
			BRESP <= RESP_OK;
		end else begin
			wr_rdy_reg <= !wr_rdy_reg && !BVALID && AWVALID && WVALID;
			if (wr_hs) begin
				BVALID <= 1'b1;
				// unmapped or read-only address answers an error
				BRESP <= (wr_ctrl || wr_baud || AWADDR == OFF_STAT
					|| AWADDR == OFF_TXH) ? RESP_OK : RESP_SLVERR;
			end else if (BREADY)
				BVALID <= 1'b0;
		end
	end
	assign AWREADY = wr_rdy_reg;
	assign WREADY = wr_rdy_reg;

	// =========
	// control and divisor registers
	// merged word first: a function result cannot be part-selected
	assign ctrl_merged = merge(32'(ctrl_reg), WDATA, WSTRB);
	assign baud_merged = merge(32'(baud_reg), WDATA, WSTRB);

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ctrl_reg <= CTRL_RST;
			baud_reg <= BAUD_RST[DIV_W-1:0];
		end else begin
			if (wr_ctrl)
				ctrl_reg <= ctrl_merged[CTRL_W-1:0];
			if (wr_baud)
				baud_reg <= baud_merged[DIV_W-1:0];
		end
	end

	// =========
	// status image
	always_comb begin
		stat_word = 32'h0000_0000;
		stat_word[SB_TDE] = tx_empty_reg;
		stat_word[SB_TX_END_FLAG] = tx_end_reg;
		stat_word[SB_RXF] = rx_full_reg;
		stat_word[SB_OVR] = ovr_reg;
		stat_word[SB_FER] = fer_reg;
		stat_word[SB_PER] = per_reg;
	end

	// =========
	// read channel
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			rd_rdy_reg <= 1'b0;
			RVALID <= 1'b0;
			RRESP <= RESP_OK;
			RDATA <= 32'h0000_0000;
		end else begin
			rd_rdy_reg <= !rd_rdy_reg && !RVALID && ARVALID;
			if (rd_hs) begin
				RVALID <= 1'b1;
				RRESP <= RESP_OK;
				unique case (ARADDR)
					OFF_CTRL: RDATA <= 32'(ctrl_reg);
					OFF_STAT: RDATA <= stat_word;
					OFF_TXH: RDATA <= {24'h000000, tx_hold_reg};
					OFF_RXH: RDATA <= {24'h000000, rx_hold_reg};
					OFF_BAUD: RDATA <= 32'(baud_reg);
					default: begin
						RDATA <= 32'h0000_0000;
						RRESP <= RESP_SLVERR;
					end
				endcase
			end else if (RREADY)
				RVALID <= 1'b0;
		end
	end
	assign ARREADY = rd_rdy_reg;

	// =========
	// base clock divider and line synchroniser
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			div_cnt_reg <= '0;
			tick_reg <= 1'b0;
			rxd_meta_reg <= 1'b1;
			rxd_sync_reg <= 1'b1;
		end else begin
			rxd_meta_reg <= RXD;
			rxd_sync_reg <= rxd_meta_reg;
			tick_reg <= (div_cnt_reg == '0);
			if (div_cnt_reg == '0)
				div_cnt_reg <= baud_reg;
			else
				div_cnt_reg <= div_cnt_reg - 1'b1;
		end
	end

	// =========
	// transmit engine
	// synchronous mode will not start while an error is pending
	assign tx_load = tx_en && tx_state_reg == TX_IDLE && !tx_empty_reg
		&& !(sync && err_any);
	assign bit_end = tick_reg && tx_cnt_reg == OVS_LAST;
	assign tx_last = bit_end && (tx_state_reg == TX_STOP || (sync
		&& tx_state_reg == TX_DATA && tx_bit_reg == LAST_BIT));

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			tx_state_reg <= TX_IDLE;
			tx_cnt_reg <= 4'h0;
			tx_bit_reg <= 3'h0;
			tx_sr_reg <= 8'h00;
			tx_line_reg <= 1'b1;
			tx_par_reg <= 1'b0;
		end else if (!tx_en) begin
			// disable aborts any frame at once
			tx_state_reg <= TX_IDLE;
			tx_cnt_reg <= 4'h0;
			tx_line_reg <= 1'b1;
		end else if (tx_load) begin
			tx_sr_reg <= tx_hold_reg;
			tx_cnt_reg <= 4'h0;
			tx_bit_reg <= 3'h0;
			tx_par_reg <= ctrl_reg[CB_PODD];
			tx_state_reg <= sync ? TX_DATA : TX_START;
			tx_line_reg <= sync ? tx_hold_reg[0] : 1'b0;
		end else if (tick_reg && tx_state_reg != TX_IDLE) begin
			tx_cnt_reg <= tx_cnt_reg + 4'h1;
			if (bit_end) begin
				unique case (tx_state_reg)
					TX_START: begin
						tx_state_reg <= TX_DATA;
						tx_line_reg <= tx_sr_reg[0];
					end
					TX_DATA: begin
						tx_par_reg <= tx_par_reg ^ tx_sr_reg[0];
						tx_sr_reg <= tx_sr_reg >> 1;
						tx_bit_reg <= tx_bit_reg + 3'h1;
						if (tx_bit_reg != LAST_BIT)
							tx_line_reg <= tx_sr_reg[1];
						else if (sync)
							// last bit level is held
							tx_state_reg <= TX_IDLE;
						else if (ctrl_reg[CB_PEN]) begin
							tx_state_reg <= TX_PAR;
							tx_line_reg <= tx_par_reg ^ tx_sr_reg[0];
						end else begin
							tx_state_reg <= TX_STOP;
							tx_line_reg <= 1'b1;
						end
					end
					TX_PAR: begin
						tx_state_reg <= TX_STOP;
						tx_line_reg <= 1'b1;
					end
					TX_STOP: tx_state_reg <= TX_IDLE;
					default: tx_state_reg <= TX_IDLE;
				endcase
			end
		end
	end

	// =========
	// transmit flags and holding register
	// a write always lands, so an unsent byte is overwritten
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			tx_empty_reg <= TDE_RST;
			tx_end_reg <= TX_END_FLAG_RST;
			tx_hold_reg <= 8'h00;
		end else begin
			if (wr_txh) begin
				tx_hold_reg <= WDATA[7:0];
				tx_empty_reg <= 1'b0;
			end else if (tx_load)
				tx_empty_reg <= 1'b1;
			// end of frame with nothing queued; set wins
			if (tx_last && tx_empty_reg)
				tx_end_reg <= 1'b1;
			else if (wr_txh)
				tx_end_reg <= 1'b0;
		end
	end

	// =========
	// receiver
	// clocked mode samples on the rising clock edge of the own clock
	assign sync_samp = sync && rx_en && tick_reg
		&& tx_state_reg == TX_DATA && tx_cnt_reg == SAMPLE_CNT;

	ssu_rx u_rx (
		.clk(CLK),
		.rst(RST),
		.tick(tick_reg),
		.rxd(rxd_sync_reg),
		.async_en(rx_en && !sync),
		.par_en(ctrl_reg[CB_PEN]),
		.par_odd(ctrl_reg[CB_PODD]),
		.sync_samp(sync_samp),
		.sync_clr(tx_load),
		.done(rx_done),
		.data(rx_data),
		.framing_flag(rx_fer),
		.per(rx_per)
	);

	// =========
	// receive flags; hardware sets win over software clears
	// clearing rx enable leaves the error flags alone
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			rx_full_reg <= 1'b0;
			ovr_reg <= 1'b0;
			fer_reg <= 1'b0;
			per_reg <= 1'b0;
			rx_hold_reg <= 8'h00;
		end else begin
			// full only for a clean frame into an empty register
			if (rx_done && !rx_full_reg && !rx_fer && !rx_per)
				rx_full_reg <= 1'b1;
			else if (rd_rxh)
				rx_full_reg <= 1'b0;
			if (rx_done && !rx_full_reg)
				rx_hold_reg <= rx_data;
			if (rx_done && rx_full_reg)
				ovr_reg <= 1'b1;
			else if (wr_stat && !WDATA[SB_OVR])
				ovr_reg <= 1'b0;
			if (rx_done && rx_fer)
				fer_reg <= 1'b1;
			else if (wr_stat && !WDATA[SB_FER])
				fer_reg <= 1'b0;
			if (rx_done && rx_per)
				per_reg <= 1'b1;
			else if (wr_stat && !WDATA[SB_PER])
				per_reg <= 1'b0;
		end
	end

	// =========
	// pins
	assign sck_use = sync && ctrl_reg[CB_SCKO] && (tx_en || rx_en);
	assign sck_level = (tx_state_reg == TX_DATA) ? tx_cnt_reg[3] : 1'b1;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			TXD_O <= 1'b1;
			TXD_OE <= 1'b0;
			SCK_O <= 1'b1;
			SCK_OE <= 1'b0;
			sck_use_reg <= 1'b0;
		end else begin
			// disabled transmitter hands the pin to the port bits
			TXD_O <= tx_en ? tx_line_reg : ctrl_reg[CB_PDAT];
			TXD_OE <= tx_en | ctrl_reg[CB_PDIR];
			sck_use_reg <= sck_use;
			// on release the pin is driven low for one cycle
			SCK_OE <= sck_use | sck_use_reg;
			SCK_O <= sck_use ? sck_level : 1'b0;
		end
	end

	// =========
	// interrupt requests, all OR-ed onto one line
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			TX_EMPTY_IRQ <= 1'b0;
			TX_END_IRQ <= 1'b0;
			RX_FULL_IRQ <= 1'b0;
			RX_ERROR_IRQ <= 1'b0;
			IRQ <= 1'b0;
		end else begin
			TX_EMPTY_IRQ <= tx_irq_enable & tx_empty_reg;
			TX_END_IRQ <= tx_end_irq_enable & tx_end_reg;
			RX_FULL_IRQ <= rx_irq_enable & rx_full_reg;
			RX_ERROR_IRQ <= rx_irq_enable & err_any;
			IRQ <= (tx_irq_enable & tx_empty_reg) | (tx_end_irq_enable & tx_end_reg)
				| (rx_irq_enable & (rx_full_reg | err_any));
		end
	end

	// =========
	// checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	AST_TXI: assert property (tx_irq_enable && tx_empty_reg |=> TX_EMPTY_IRQ)
		else $error("tx empty request missing");
	AST_TEI: assert property (!tx_end_irq_enable |=> !TX_END_IRQ)
		else $error("tx end request while disabled");
	AST_RXI: assert property ($rose(rx_full_reg) && rx_irq_enable
		|=> RX_FULL_IRQ)
		else $error("rx full request missing");
	AST_ERI: assert property (rx_irq_enable && err_any |=> RX_ERROR_IRQ && IRQ)
		else $error("rx error request missing");
	AST_IRQ: assert property (IRQ |-> $past(tx_irq_enable && tx_empty_reg
		|| tx_end_irq_enable && tx_end_reg || rx_irq_enable && (rx_full_reg || err_any)))
		else $error("interrupt without enabled source");
	AST_TXH: assert property (wr_txh |=> !tx_empty_reg
		&& tx_hold_reg == $past(WDATA[7:0]))
		else $error("holding write did not clear empty");
	AST_OVR: assert property (rx_done && rx_full_reg && !rd_rxh
		|=> ovr_reg && rx_full_reg
		&& rx_hold_reg == $past(rx_hold_reg))
		else $error("overrun handling wrong");
	AST_FER: assert property (rx_done && !rx_full_reg && rx_fer
		|=> fer_reg && !rx_full_reg
		&& rx_hold_reg == $past(rx_data))
		else $error("framing error handling wrong");
	AST_RDR: assert property (rd_rxh && !rx_done |=> !rx_full_reg)
		else $error("holding read did not clear full");
	AST_PORT: assert property (!tx_en |=> TXD_O == $past(ctrl_reg[CB_PDAT])
		&& TXD_OE == $past(ctrl_reg[CB_PDIR]))
		else $error("port bits not on tx pin");
	AST_TEOFF: assert property (!tx_en |=> tx_state_reg == TX_IDLE)
		else $error("transmitter not reset");
	AST_SYNC: assert property (sync && err_any
		&& tx_state_reg == TX_IDLE |=> tx_state_reg == TX_IDLE)
		else $error("synchronous tx started with error");
	AST_SCK: assert property ($fell(sck_use) |=> SCK_OE && !SCK_O
		##1 !SCK_OE)
		else $error("clock pin release wrong");

	COV_OVR: cover property (rx_done && rx_full_reg);
	COV_TX_END_FLAG: cover property (tx_last && tx_empty_reg);
	COV_BRK: cover property (rx_done && rx_fer ##[1:1000] rx_done && rx_fer);
	COV_B2B: cover property (tx_last ##[1:4] tx_load);

endmodule

// File: logic/ssu_pkg.sv
// Purpose: shared constants and types of the serial status unit
// Assumes: 32-bit AXI4-Lite register port, byte addresses below
// Notes: one package for the top and the receiver

package ssu_pkg;

	// =========
	// register map (byte addresses)
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_CTRL = 8'h00; // serial_control_reg
	localparam logic [7:0] OFF_STAT = 8'h04; // serial_status_reg
	localparam logic [7:0] OFF_TXH = 8'h08; // tx_holding_reg
	localparam logic [7:0] OFF_RXH = 8'h0C; // rx_holding_reg
	localparam logic [7:0] OFF_BAUD = 8'h10; // tick divisor

	// =========
	// control field positions
	localparam int CB_TIE = 0; // tx_irq_enable
	localparam int CB_RIE = 1; // rx_irq_enable
	localparam int CB_TX_END_IRQ_ENABLE = 2; // tx_end_irq_enable
	localparam int CB_TE = 3; // tx_enable
	localparam int CB_RE = 4; // rx_enable
	localparam int CB_SYNC = 5; // synchronous mode
	localparam int CB_PEN = 6; // parity enable
	localparam int CB_PODD = 7; // odd parity
	localparam int CB_PDAT = 8; // port_data_bit
	localparam int CB_PDIR = 9; // port_dir_bit
	localparam int CB_SCKO = 10; // serial clock pin is clock output
	localparam int CTRL_W = 11;

	// =========
	// status field positions
	localparam int SB_TDE = 0; // tx_empty_flag
	localparam int SB_TX_END_FLAG = 1; // tx_end_flag
	localparam int SB_RXF = 2; // rx_full_flag
	localparam int SB_OVR = 3; // overrun_flag
	localparam int SB_FER = 4; // framing_flag
	localparam int SB_PER = 5; // parity flag

	// =========
	// reset values
	localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;
	localparam logic [15:0] BAUD_RST = 16'h0000;
	localparam logic TDE_RST = 1'b1;
	localparam logic TX_END_FLAG_RST = 1'b1;

	// =========
	// timing in base-clock ticks
	localparam int OVERSAMPLE = 16; // base clock per bit
	localparam logic [3:0] OVS_LAST = 4'(OVERSAMPLE - 1);
	localparam logic [3:0] SAMPLE_CNT = 4'h7; // eighth tick of a bit
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// =========
	// state types
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR,
		TX_STOP} ssu_tx_e;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR,
		RX_STOP} ssu_rx_e;

endpackage

// File: logic/ssu_rx.sv
// Purpose: receive shifter, asynchronous and clocked-synchronous
// Assumes: rxd already synchronised, tick is the 16x base enable
// Notes: result fields are valid in the cycle of done only

`timescale 1ns/100ps

module ssu_rx (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// timing and line
	input wire logic tick,
	input wire logic rxd,
	// mode
	input wire logic async_en,
	input wire logic par_en,
	input wire logic par_odd,
	// synchronous sampling
	input wire logic sync_samp,
	input wire logic sync_clr,
	// result
	output logic done,
	output logic [7:0] data,
	output logic framing_flag,
	output logic per
);
	import ssu_pkg::*;

	ssu_rx_e st_reg; // frame state
	logic [3:0] cnt_reg; // ticks within a bit
	logic [2:0] bit_reg; // data bit index
	logic par_reg; // running parity
	logic prev_reg; // line level on previous tick
	logic brk_reg; // last frame ended low

	// =========
	// frame engine
	// restarting on a low level after a low stop bit keeps a break
	// line producing frames, so the framing flag comes back
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_reg <= RX_IDLE;
			cnt_reg <= 4'h0;
			bit_reg <= 3'h0;
			par_reg <= 1'b0;
			prev_reg <= 1'b1;
			brk_reg <= 1'b0;
			done <= 1'b0;
			data <= 8'h00;
			framing_flag <= 1'b0;
			per <= 1'b0;
		end else begin
			done <= 1'b0;
			// clocked mode: one bit per sample strobe
			if (sync_clr) begin
				bit_reg <= 3'h0;
			end else if (sync_samp) begin
				data <= {rxd, data[7:1]};
				bit_reg <= bit_reg + 3'h1;
				framing_flag <= 1'b0;
				per <= 1'b0;
				done <= (bit_reg == LAST_BIT);
			end else if (!async_en) begin
				st_reg <= RX_IDLE;
				brk_reg <= 1'b0;
			end else if (tick) begin
				prev_reg <= rxd;
				cnt_reg <= cnt_reg + 4'h1;
				unique case (st_reg)
					RX_IDLE: begin
						// falling edge, or low after a break frame
						if (!rxd && (prev_reg || brk_reg)) begin
							st_reg <= RX_START;
							cnt_reg <= 4'h1;
						end
					end
					RX_START: begin
						if (cnt_reg == SAMPLE_CNT) begin
							// glitch, not a start bit
							if (rxd)
								st_reg <= RX_IDLE;
							else begin
								st_reg <= RX_DATA;
								bit_reg <= 3'h0;
								par_reg <= par_odd;
							end
						end
					end
					RX_DATA: begin
						if (cnt_reg == SAMPLE_CNT) begin
							data <= {rxd, data[7:1]};
							par_reg <= par_reg ^ rxd;
							bit_reg <= bit_reg + 3'h1;
							if (bit_reg == LAST_BIT)
								st_reg <= par_en ? RX_PAR : RX_STOP;
						end
					end
					RX_PAR: begin
						if (cnt_reg == SAMPLE_CNT) begin
							per <= par_reg ^ rxd;
							st_reg <= RX_STOP;
						end
					end
					RX_STOP: begin
						if (cnt_reg == SAMPLE_CNT) begin
							framing_flag <= !rxd;
							brk_reg <= !rxd;
							done <= 1'b1;
							st_reg <= RX_IDLE;
							if (!par_en)
								per <= 1'b0;
						end
					end
					default: st_reg <= RX_IDLE;
				endcase
			end
		end
	end

endmodule

// File: sim/ssu_far_end.sv
// Purpose: far-end serial transceiver, 8 data bits, one stop bit
// Assumes: unit divisor left at 0, so one bit lasts 16 CLK cycles
// Notes: line_in arrives already resolved with the pull-up

`timescale 1ns/100ps

module ssu_far_end (
	// clock
	input wire logic clk,
	// line
	input wire logic line_in,
	output logic rxd,
	// received byte
	output logic [7:0] got,
	output logic got_v
);
	localparam int BIT_CYC = 16; // cycles per bit at divisor 0
	logic [7:0] sh; // receive shifter
	int i;
	initial begin
		rxd = 1'b1;
		got = 8'h00;
		got_v = 1'b0;
	end
	// ==========
	// transmit: start, data lsb first, stop, then mark
	task send(input logic [7:0] d, input logic stop);
		int k;
		logic [9:0] f;
		f = {stop, d, 1'b0};
		for (k = 0; k < 10; k++) begin
			@(posedge clk);
			rxd <= f[k];
			repeat (BIT_CYC - 1) @(posedge clk);
		end
		@(posedge clk);
		rxd <= 1'b1;
		repeat (BIT_CYC) @(posedge clk);
	endtask
	// hold the line, low means break
	task hold(input logic v);
		@(posedge clk);
		rxd <= v;
	endtask
	// ==========
	// receive: mid-bit sampling from the start edge
	always begin
		@(negedge line_in);
		repeat (BIT_CYC / 2) @(posedge clk);
		for (i = 0; i < 8; i++) begin
			repeat (BIT_CYC) @(posedge clk);
			sh[i] = line_in;
		end
		repeat (BIT_CYC) @(posedge clk);
		got <= sh;
		got_v <= 1'b1;
		@(posedge clk);
		got_v <= 1'b0;
	end
endmodule

// File: sim/tb_top.sv
// Purpose: self-checking bench for the serial status unit
// Assumes: AXI4-Lite master here, far end in ssu_far_end
// Notes: read and tx results are checked from queues of notes

`timescale 1ns/100ps

module tb_top;
	import ssu_pkg::*;
	// ==========
	// signals
	logic CLK = 1'b0;
	logic RST = 1'b1;
	logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
	logic [31:0] WDATA = 32'h0, RDATA;
	logic [3:0] WSTRB = 4'h0;
	logic AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
	logic [1:0] BRESP, RRESP;
	logic RXD, TXD_O, TXD_OE, line, got_v, SCK_O, SCK_OE;
	logic TX_EMPTY_IRQ, TX_END_IRQ, RX_FULL_IRQ, RX_ERROR_IRQ, IRQ;
	logic [7:0] got, a, b, c;
	logic [31:0] rq[$], rm[$]; // expected read data and mask
	logic [1:0] rr[$]; // expected read response
	logic [7:0] tq[$]; // bytes the far end must see
	int n_fail = 0;
	int tests_run = 0;
	integer seed = 32'h2213;
	always #12.5 CLK = ~CLK;
	// released line floats high through the pull-up
	assign line = TXD_OE ? TXD_O : 1'b1;
	ssu_serial_unit dut (.CLK(CLK), .RST(RST), .AWADDR(AWADDR),
		.AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
		.WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
		.BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
		.ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
		.RREADY(RREADY), .RXD(RXD), .TXD_O(TXD_O), .TXD_OE(TXD_OE),
		.SCK_O(SCK_O), .SCK_OE(SCK_OE), .TX_EMPTY_IRQ(TX_EMPTY_IRQ),
		.TX_END_IRQ(TX_END_IRQ), .RX_FULL_IRQ(RX_FULL_IRQ),
		.RX_ERROR_IRQ(RX_ERROR_IRQ), .IRQ(IRQ));
	ssu_far_end u_far (.clk(CLK), .line_in(line), .rxd(RXD), .got(got),
		.got_v(got_v));
	// ==========
	// reporting
	task give_verdict;
		$display("fails %0d checks %0d", n_fail, tests_run);
		if (n_fail == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// bounded wait on one handshake output, index picks it
	task wt(input int s);
		int k;
		logic [3:0] v;
		for (k = 0; k < 99; k++) begin
			@(posedge CLK);
			v = {RVALID, ARREADY, BVALID, AWREADY};
			if (v[s] === 1'b1)
				break;
		end
		if (k == 99) begin
			n_fail++;
			$display("[ERR] %0t bus timeout", $time);
			give_verdict;
		end
	endtask
	// ==========
	// bus cycles
	task wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] r);
		@(posedge CLK);
		AWADDR <= ad;
		WDATA <= d;
		WSTRB <= 4'hF;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		wt(0);
		AWVALID <= 1'b0;
		WVALID <= 1'b0;
		wt(1);
		BREADY <= 1'b0;
		chk(BRESP, r);
	endtask
	task rd(input logic [7:0] ad, input logic [31:0] e, input logic [31:0] m,
		input logic [1:0] r);
		rq.push_back(e);
		rm.push_back(m);
		rr.push_back(r);
		@(posedge CLK);
		ARADDR <= ad;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		wt(2);
		ARVALID <= 1'b0;
		wt(3);
		RREADY <= 1'b0;
	endtask
	// ==========
	// watcher: oldest note against each result
	always @(posedge CLK) begin
		if (RVALID === 1'b1 && RREADY === 1'b1) begin
			chk(RDATA & rm.pop_front(), rq.pop_front());
			chk(RRESP, rr.pop_front());
		end
		if (got_v === 1'b1)
			chk(got, tq.pop_front());
	end
	// ==========
	// main sequence
	initial begin
		repeat (20) @(posedge CLK);
		RST <= 1'b0;
		rd(OFF_STAT, 32'h3, 32'h3F, RESP_OK);
		chk(IRQ, 1'b0);
		rd(8'h14, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
		wr(8'h14, 32'h1, RESP_SLVERR);
		wr(OFF_RXH, 32'h1, RESP_SLVERR);
		wr(OFF_CTRL, 32'h5, RESP_OK);
		repeat (2) @(posedge CLK);
		chk(TX_EMPTY_IRQ, 1'b1);
		chk(TX_END_IRQ, 1'b1);
		chk(IRQ, 1'b1);
		// tx: third write overwrites the queued byte; irq enables after load
		wr(OFF_CTRL, 32'h18, RESP_OK);
		a = 8'($random(seed));
		b = 8'($random(seed));
		c = 8'($random(seed));
		tq.push_back(a);
		tq.push_back(c);
		wr(OFF_TXH, {24'h0, a}, RESP_OK);
		wr(OFF_TXH, {24'h0, b}, RESP_OK);
		wr(OFF_TXH, {24'h0, c}, RESP_OK);
		wr(OFF_CTRL, 32'h1D, RESP_OK);
		rd(OFF_STAT, 32'h0, 32'h3, RESP_OK);
		chk(TX_EMPTY_IRQ, 1'b0);
		repeat (400) @(posedge CLK);
		rd(OFF_STAT, 32'h3, 32'h3, RESP_OK);
		// rx: normal frame, then overrun
		wr(OFF_CTRL, 32'h12, RESP_OK);
		u_far.send(a, 1'b1);
		repeat (6) @(posedge CLK);
		chk(RX_FULL_IRQ, 1'b1);
		rd(OFF_RXH, {24'h0, a}, 32'hFF, RESP_OK);
		rd(OFF_STAT, 32'h0, 32'h3C, RESP_OK);
		u_far.send(b, 1'b1);
		u_far.send(c, 1'b1);
		repeat (6) @(posedge CLK);
		rd(OFF_STAT, 32'hC, 32'h3C, RESP_OK);
		rd(OFF_RXH, {24'h0, b}, 32'hFF, RESP_OK);
		rd(OFF_STAT, 32'h8, 32'h3C, RESP_OK);
		chk(RX_ERROR_IRQ, 1'b1);
		wr(OFF_CTRL, 32'h10, RESP_OK);
		repeat (2) @(posedge CLK);
		chk(RX_ERROR_IRQ, 1'b0);
		chk(IRQ, 1'b0);
		wr(OFF_STAT, 32'h0, RESP_OK);
		// break: framing errors keep coming back
		wr(OFF_CTRL, 32'h12, RESP_OK);
		u_far.hold(1'b0);
		repeat (250) @(posedge CLK);
		rd(OFF_STAT, 32'h10, 32'h3C, RESP_OK);
		rd(OFF_RXH, 32'h0, 32'hFF, RESP_OK);
		chk(RX_ERROR_IRQ, 1'b1);
		wr(OFF_STAT, 32'h0, RESP_OK);
		repeat (250) @(posedge CLK);
		rd(OFF_STAT, 32'h10, 32'h10, RESP_OK);
		// port mode: break driven by port bits
		wr(OFF_CTRL, 32'h208, RESP_OK);
		wr(OFF_CTRL, 32'h200, RESP_OK);
		repeat (2) @(posedge CLK);
		chk(TXD_O, 1'b0);
		chk(TXD_OE, 1'b1);
		wr(OFF_CTRL, 32'h300, RESP_OK);
		repeat (2) @(posedge CLK);
		chk(TXD_O, 1'b1);
		// sync mode: pending framing error holds tx off, clock pin release
		wr(OFF_CTRL, 32'h428, RESP_OK);
		@(posedge CLK);
		chk(SCK_OE, 1'b1);
		chk(SCK_O, 1'b1);
		wr(OFF_TXH, {24'h0, a}, RESP_OK);
		repeat (4) @(posedge CLK);
		rd(OFF_STAT, 32'h10, 32'h13, RESP_OK);
		wr(OFF_CTRL, 32'h300, RESP_OK);
		@(posedge CLK);
		chk(SCK_OE, 1'b1);
		chk(SCK_O, 1'b0);
		@(posedge CLK);
		chk(SCK_OE, 1'b0);
		chk(tq.size(), 0);
		give_verdict;
	end
endmodule
